/* File: shared/sync_link_params.svh */
// Constants for the synchronous command link framer.
// Included by the package and the design files by bare name.
`ifndef SYNC_LINK_PARAMS_SVH
`define SYNC_LINK_PARAMS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define SL_WORD_W 64
`define SL_CNT_W 40
`define SL_BUNCH_W 16
`define SL_TFID_W 24
`define SL_BYTE_W 8
`define SL_BODY_W 32
`define SL_COMMA 8'hbc
`define SL_COMMA_LSB 56
`define SL_CMD_LSB 40
`define SL_EXT_CODE_LSB 48
`define SL_EXT_PROMPT_LSB 40

// Flexible area type field
`define SL_FLEX_COUNT 8'h00
`define SL_FLEX_CMD 8'h01

// Prompt flag bit positions
`define SL_PF_HAD_REV 0
`define SL_PF_HAD_FILL 1
`define SL_PF_EL_REV 2
`define SL_PF_EL_FILL 3
`define SL_PF_TF_START 4

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SL_CMD_IDLE 8'h00
`define SL_CMD_RUN_START 8'h01
`define SL_CMD_RUN_STOP 8'h02
`define SL_CMD_RESYNC 8'h03
`define SL_CMD_APPLY_BUSY 8'h04
`define SL_CMD_RELEASE_BUSY 8'h05
`define SL_CMD_SEND_CONFIG 8'h06
`define SL_CMD_CONFIG_DONE 8'h07
`define SL_CMD_FW_TRIGGER 8'h08

// ----------------------------------------------------------------
// Queues and register map
// ----------------------------------------------------------------
`define SL_FIFO_DEPTH 8
`define SL_FIFO_AW 3
`define SL_WB_AW 8
`define SL_REG_CTRL 8'h00
`define SL_REG_RC_BODY 8'h04
`define SL_REG_RC_CMD 8'h08
`define SL_REG_STATUS 8'h0c
`define SL_REG_CNT_LO 8'h10
`define SL_REG_CNT_HI 8'h14
`define SL_CTRL_ENABLE 0
`define SL_CTRL_EXTENDED 1
`define SL_CTRL_FORCE_DT 2
`define SL_CTRL_RESET 32'h0000_0001

`endif

/* File: shared/sync_link_pkg.sv */
// Types for the synchronous command link framer.
// Relies on sync_link_params.svh for the command entry field widths.
`include "sync_link_params.svh"

package sync_link_pkg;

    typedef struct packed {
        logic [`SL_BYTE_W-1:0] code;
        logic [`SL_BODY_W-1:0] body;
    } cmd_entry_type;

    typedef struct packed {
        logic had_rev;
        logic had_fill;
        logic el_rev;
        logic el_fill;
    } beam_flags_type;

    typedef enum logic [1:0] {SRC_IDLE, SRC_FLOW, SRC_TRIG, SRC_RUN} source_type;

    typedef enum logic {LINK_OWNED, LINK_LENT} link_state_type;

endpackage : sync_link_pkg

/* File: rtl/cmd_fifo.sv */
// Command queue: fixed-depth FIFO of command entries.
// Same clock as its user; pop_data_o valid while pop_valid_o is high.
`timescale 1ns/1ps
`default_nettype none
`include "sync_link_params.svh"

module cmd_fifo (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_valid_i,
    input wire sync_link_pkg::cmd_entry_type push_data_i,
    output logic push_ready_o,
    output logic pop_valid_o,
    input wire logic pop_ready_i,
    output sync_link_pkg::cmd_entry_type pop_data_o
);
    import sync_link_pkg::*;

    cmd_entry_type mem_ff [`SL_FIFO_DEPTH];
    logic [`SL_FIFO_AW-1:0] wr_ff;
    logic [`SL_FIFO_AW-1:0] rd_ff;
    logic [`SL_FIFO_AW:0] used_ff;
    logic do_push;
    logic do_pop;

    assign push_ready_o = (used_ff != (`SL_FIFO_AW+1)'(`SL_FIFO_DEPTH));
    assign pop_valid_o = (used_ff != '0);
    assign pop_data_o = mem_ff[rd_ff];
    assign do_push = push_valid_i && push_ready_o;
    assign do_pop = pop_ready_i && pop_valid_o;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_ff[wr_ff] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            used_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (do_push && !do_pop) begin
                used_ff <= used_ff + 1'b1;
            end else if (do_pop && !do_push) begin
                used_ff <= used_ff - 1'b1;
            end
        end
    end

endmodule : cmd_fifo
`default_nettype wire

/* File: rtl/sync_command_link.sv */
// Timing unit command framer: one 64-bit word per bunch crossing.
// Assumes link_clk_i is the beam clock, asynchronous to clk_i and much slower;
// flow and trigger requests come from same-clock logic; a serialiser with
// 8b/10b coding follows and sends the top byte as a comma character.
//
// Notes on behaviour
// - 64 payload bits per crossing, 80 line
// - Baseline: counter, 16-bit command, comma byte
// - Extended: flex data, prompt flags, command, comma
// - Flexible area starts with type field
// - Beam and timeframe flags sent as prompt
// - Beam information inserted immediately, highest priority
// - Three queues drained flow, trigger, run
// - Run control parameters passed, not interpreted
// - Beam information merged into command stream
// - Truncation flagged; dead-time limits it
// - Trigger summaries compiled, decision sent out
// - Trigger status may be asynchronous link
// - Link gives clock, crossing labels, timeframes
// - Fixed latency from issue to use
// - 16-bit bunch count, 24-bit timeframe id
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sync_link_params.svh"

module sync_command_link (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`SL_WB_AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic link_clk_i,
    input wire sync_link_pkg::beam_flags_type beam_i,
    input wire logic flow_valid_i,
    input wire sync_link_pkg::cmd_entry_type flow_i,
    output logic flow_ready_o,
    input wire logic trig_valid_i,
    input wire sync_link_pkg::cmd_entry_type trig_i,
    output logic trig_ready_o,
    input wire logic config_done_i,
    output logic [`SL_WORD_W-1:0] word_o,
    output logic word_valid_o,
    output logic comma_k_o,
    output logic deadtime_o,
    output logic link_lent_o
);
    import sync_link_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // ----------------------------------------------------------------
    // Input synchronisers and crossing tick
    // ----------------------------------------------------------------
    logic [1:0] lclk_sync_ff;
    logic lclk_prev_ff;
    beam_flags_type beam_meta_ff;
    beam_flags_type beam_ff;
    logic tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Start high so reset never fakes a crossing edge
            lclk_sync_ff <= '1;
            lclk_prev_ff <= 1'b1;
            beam_meta_ff <= '0;
            beam_ff <= '0;
        end else begin
            lclk_sync_ff <= {lclk_sync_ff[0], link_clk_i};
            lclk_prev_ff <= lclk_sync_ff[1];
            beam_meta_ff <= beam_i;
            beam_ff <= beam_meta_ff;
        end
    end

    assign tick = lclk_sync_ff[1] && !lclk_prev_ff;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] rc_body_ff;
    logic rc_drop_ff;
    logic wb_ack_ff;
    logic [31:0] wb_dat_ff;
    logic bus_req;
    logic bus_wr;
    logic rc_push;
    logic rc_ready;
    logic [`SL_CNT_W-1:0] count_ff;
    logic busy_ff;
    link_state_type link_ff;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    assign bus_wr = bus_req && wb_we_i;
    assign rc_push = bus_wr && (wb_adr_i == `SL_REG_RC_CMD) && wb_sel_i[0];
    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= '0;
        end else begin
            wb_ack_ff <= bus_req;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `SL_REG_CTRL: wb_dat_ff <= ctrl_ff;
                    `SL_REG_RC_BODY: wb_dat_ff <= rc_body_ff;
                    `SL_REG_STATUS: wb_dat_ff <= {28'h0, rc_drop_ff, !rc_ready,
                                                  busy_ff, link_ff == LINK_LENT};
                    `SL_REG_CNT_LO: wb_dat_ff <= count_ff[31:0];
                    `SL_REG_CNT_HI: wb_dat_ff <= {24'h0, count_ff[`SL_CNT_W-1:32]};
                    default: wb_dat_ff <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `SL_CTRL_RESET;
            rc_body_ff <= '0;
        end else if (bus_wr) begin
            if (wb_adr_i == `SL_REG_CTRL) begin
                ctrl_ff <= merge_bytes(ctrl_ff, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == `SL_REG_RC_BODY) begin
                rc_body_ff <= merge_bytes(rc_body_ff, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Lost run command sticky; write one to clear, loss wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_drop_ff <= 1'b0;
        end else if (rc_push && !rc_ready) begin
            rc_drop_ff <= 1'b1;
        end else if (bus_wr && wb_adr_i == `SL_REG_STATUS && wb_sel_i[0] && wb_dat_i[3]) begin
            rc_drop_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Request queues
    // ----------------------------------------------------------------
    cmd_entry_type flow_head;
    cmd_entry_type trig_head;
    cmd_entry_type rc_head;
    logic flow_has;
    logic trig_has;
    logic rc_has;
    logic flow_pop;
    logic trig_pop;
    logic rc_pop;
    source_type pick;

    cmd_fifo flow_q (
        .clk_i(clk_i), .rst_i(rst_i),
        .push_valid_i(flow_valid_i), .push_data_i(flow_i), .push_ready_o(flow_ready_o),
        .pop_valid_o(flow_has), .pop_ready_i(flow_pop), .pop_data_o(flow_head)
    );

    cmd_fifo trig_q (
        .clk_i(clk_i), .rst_i(rst_i),
        .push_valid_i(trig_valid_i), .push_data_i(trig_i), .push_ready_o(trig_ready_o),
        .pop_valid_o(trig_has), .pop_ready_i(trig_pop), .pop_data_o(trig_head)
    );

    // Run commands carry software's body untouched
    cmd_fifo rc_q (
        .clk_i(clk_i), .rst_i(rst_i),
        .push_valid_i(rc_push), .push_data_i({wb_dat_i[7:0], rc_body_ff}),
        .push_ready_o(rc_ready),
        .pop_valid_o(rc_has), .pop_ready_i(rc_pop), .pop_data_o(rc_head)
    );

    // ----------------------------------------------------------------
    // Precedence merge
    // ----------------------------------------------------------------
    cmd_entry_type chosen;
    logic send;

    assign send = tick && ctrl_ff[`SL_CTRL_ENABLE];

    always_comb begin
        pick = SRC_IDLE;
        chosen = '{code: `SL_CMD_IDLE, body: '0};
        if (flow_has) begin
            pick = SRC_FLOW;
            chosen = flow_head;
        end else if (trig_has) begin
            pick = SRC_TRIG;
            chosen = trig_head;
        end else if (rc_has && link_ff == LINK_OWNED) begin
            pick = SRC_RUN;
            chosen = rc_head;
        end
    end

    assign flow_pop = send && pick == SRC_FLOW;
    assign trig_pop = send && pick == SRC_TRIG;
    assign rc_pop = send && pick == SRC_RUN;

    // ----------------------------------------------------------------
    // Crossing counter, dead-time and link hand-over
    // ----------------------------------------------------------------
    logic tf_start;

    assign tf_start = (count_ff[`SL_BUNCH_W-1:0] == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (send) begin
            if (chosen.code == `SL_CMD_RESYNC) begin
                count_ff <= '0;
            end else begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    // Sent SL_CMD_APPLY_BUSY commands raise dead-time until an SL_CMD_RELEASE_BUSY is sent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
        end else if (send && chosen.code == `SL_CMD_APPLY_BUSY) begin
            busy_ff <= 1'b1;
        end else if (send && chosen.code == `SL_CMD_RELEASE_BUSY) begin
            busy_ff <= 1'b0;
        end
    end

    assign deadtime_o = busy_ff || ctrl_ff[`SL_CTRL_FORCE_DT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_ff <= LINK_OWNED;
        end else begin
            unique case (link_ff)
                LINK_OWNED: begin
                    if (send && chosen.code == `SL_CMD_SEND_CONFIG) begin
                        link_ff <= LINK_LENT;
                    end
                end
                LINK_LENT: begin
                    if (config_done_i) begin
                        link_ff <= LINK_OWNED;
                    end
                end
            endcase
        end
    end

    assign link_lent_o = (link_ff == LINK_LENT);

    // ----------------------------------------------------------------
    // Word builder
    // ----------------------------------------------------------------
    logic [`SL_BYTE_W-1:0] prompt;
    logic [`SL_WORD_W-1:0] word_ff;
    logic valid_ff;
    logic [`SL_CNT_W-1:0] flex;

    always_comb begin
        prompt = '0;
        prompt[`SL_PF_HAD_REV] = beam_ff.had_rev;
        prompt[`SL_PF_HAD_FILL] = beam_ff.had_fill;
        prompt[`SL_PF_EL_REV] = beam_ff.el_rev;
        prompt[`SL_PF_EL_FILL] = beam_ff.el_fill;
        prompt[`SL_PF_TF_START] = tf_start;
    end

    // Type byte first, then its body
    assign flex = (pick == SRC_IDLE) ? {count_ff[`SL_BODY_W-1:0], `SL_FLEX_COUNT}
                                     : {chosen.body, `SL_FLEX_CMD};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= send;
            if (send) begin
                if (ctrl_ff[`SL_CTRL_EXTENDED]) begin
                    word_ff <= {`SL_COMMA, chosen.code, prompt, flex};
                end else begin
                    word_ff <= {`SL_COMMA, chosen.body[7:0], chosen.code, count_ff};
                end
            end
        end
    end

    assign word_o = word_ff;
    assign word_valid_o = valid_ff;
    assign comma_k_o = valid_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fixed_latency: assert property (send |=> word_valid_o && $past(send))
        else $error("Word not issued one cycle after crossing");
    a_no_stray_word: assert property (word_valid_o |-> $past(tick))
        else $error("Word issued without a crossing");
    a_comma_top: assert property (word_valid_o
                                  |-> word_o[`SL_COMMA_LSB +: `SL_BYTE_W] == `SL_COMMA)
        else $error("Comma byte missing");
    a_flow_first: assert property (send && flow_has |-> flow_pop && !trig_pop && !rc_pop)
        else $error("Flow queue not served first");
    a_trig_before_run: assert property (send && !flow_has && trig_has |-> trig_pop && !rc_pop)
        else $error("Trigger queue not served before run control");
    a_lent_holds_run: assert property (link_lent_o |-> !rc_pop)
        else $error("Run command drained while link lent");
    a_counter_step: assert property (send && chosen.code != `SL_CMD_RESYNC
                                      |=> count_ff == $past(count_ff) + 1'b1)
        else $error("Crossing counter did not advance");
    a_prompt_flags: assert property (send && ctrl_ff[`SL_CTRL_EXTENDED]
                                     |=> word_o[`SL_EXT_PROMPT_LSB +: `SL_BYTE_W] == $past(prompt))
        else $error("Prompt flags not placed");
    // Extended idle words still carry live prompt flags
    a_idle_word: assert property (send && !flow_has && !trig_has && !rc_has
                                  |=> word_valid_o
                                      && word_o[`SL_EXT_CODE_LSB +: `SL_BYTE_W] == '0
                                      && ($past(ctrl_ff[`SL_CTRL_EXTENDED])
                                          || word_o[`SL_CMD_LSB +: `SL_BYTE_W] == `SL_CMD_IDLE))
        else $error("Idle crossing word malformed");
    a_busy_apply: assert property (send && chosen.code == `SL_CMD_APPLY_BUSY
                                   |=> deadtime_o [*2])
        else $error("Dead-time not applied");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus request not answered next cycle");

    c_extended_word: cover property (send && ctrl_ff[`SL_CTRL_EXTENDED]);
    c_link_handover: cover property (link_lent_o ##[1:1000] !link_lent_o);
    c_all_queues: cover property (send && flow_has && trig_has && rc_has);
    c_tf_start: cover property (send && tf_start);

endmodule : sync_command_link
`default_nettype wire

/* File: verif/agg_board_model.sv */
// Aggregation board model on the framer's word output.
// Same clock as the framer; lend_cycles_i sets how long it keeps the link.
`timescale 1ns/1ps
`default_nettype none
`include "sync_link_params.svh"

module agg_board_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`SL_WORD_W-1:0] word_i,
    input wire logic word_valid_i,
    input wire logic comma_k_i,
    input wire logic link_lent_i,
    input wire logic [15:0] lend_cycles_i,
    output logic config_done_o,
    output logic [7:0] align_err_o,
    output logic [7:0] trig_seen_o
);
    logic [15:0] held_ff;

    // Word boundary must carry the comma as a K character
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            align_err_o <= 8'h00;
        end else if (word_valid_i
                     && (word_i[63:56] !== `SL_COMMA || comma_k_i !== 1'b1)) begin
            align_err_o <= align_err_o + 8'h01;
        end
    end

    // Trigger results acted on as they arrive; no deadline on them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_seen_o <= 8'h00;
        end else if (word_valid_i && word_i[47:40] === `SL_CMD_FW_TRIGGER) begin
            trig_seen_o <= trig_seen_o + 8'h01;
        end
    end

    // Keep the lent link, then report configuration complete
    always_ff @(posedge clk_i) begin
        if (rst_i || !link_lent_i) begin
            held_ff <= 16'h0000;
            config_done_o <= 1'b0;
        end else if (held_ff == lend_cycles_i) begin
            config_done_o <= 1'b1;
        end else begin
            held_ff <= held_ff + 16'h0001;
        end
    end
endmodule : agg_board_model
`default_nettype wire

/* File: verif/sync_command_link_test.sv */
// Bench for the command word framer: Wishbone, queues, beam flags, beam clock.
// Board model sits on the word output; a word counter gives expected labels.
`timescale 1ns/1ps
`default_nettype none
`include "sync_link_params.svh"

module sync_command_link_test;
    import sync_link_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] body;
        logic dt;
        logic lent;
    } row_type;
    row_type rows [9] = '{{`SL_CMD_IDLE, 10'h0}, {`SL_CMD_RUN_START, 10'h44},
        {`SL_CMD_RUN_STOP, 10'h88}, {`SL_CMD_RESYNC, 10'hcc}, {`SL_CMD_APPLY_BUSY, 10'h112},
        {`SL_CMD_RELEASE_BUSY, 10'h154}, {`SL_CMD_SEND_CONFIG, 10'h199},
        {`SL_CMD_CONFIG_DONE, 10'h1dc}, {`SL_CMD_FW_TRIGGER, 10'h220}};
    cmd_entry_type pri [3] = '{{`SL_CMD_RUN_START, 32'h1234_5678},
        {`SL_CMD_FW_TRIGGER, 32'h0bad_f00d}, {`SL_CMD_RUN_STOP, 32'hdead_beef}};
    logic clk_i = 1'b0, rst_i = 1'b1, link_clk_i = 1'b0, ext = 1'b0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, flow_valid_i = 1'b0, trig_valid_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, align_err, trig_seen;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'h0;
    logic [15:0] lend = 16'h0014;
    logic [39:0] wcnt;
    logic [63:0] word_o;
    logic wb_ack_o, flow_ready_o, trig_ready_o, config_done_i;
    logic word_valid_o, comma_k_o, deadtime_o, link_lent_o;
    beam_flags_type beam_i = '0;
    cmd_entry_type flow_i = '0, trig_i = '0;
    int n_fail = 0, checks_done = 0, nwords = 0, k;

    sync_command_link DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
        .beam_i(beam_i), .flow_valid_i(flow_valid_i), .flow_i(flow_i),
        .flow_ready_o(flow_ready_o), .trig_valid_i(trig_valid_i), .trig_i(trig_i),
        .trig_ready_o(trig_ready_o), .config_done_i(config_done_i), .word_o(word_o),
        .word_valid_o(word_valid_o), .comma_k_o(comma_k_o), .deadtime_o(deadtime_o),
        .link_lent_o(link_lent_o));
    agg_board_model partner (.clk_i(clk_i), .rst_i(rst_i), .word_i(word_o),
        .word_valid_i(word_valid_o), .comma_k_i(comma_k_o), .link_lent_i(link_lent_o),
        .lend_cycles_i(lend), .config_done_o(config_done_i), .align_err_o(align_err),
        .trig_seen_o(trig_seen));

    initial forever #2 clk_i = ~clk_i;
    initial begin
        #1.3;
        forever #80 link_clk_i = ~link_clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [79:0] seen, input logic [79:0] want);
        checks_done++;
        if (seen !== want) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
            n_fail++;
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        check(wb_ack_o, 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic push(input logic fv, input cmd_entry_type fe, input logic tv,
                        input cmd_entry_type te);
        @(posedge clk_i);
        flow_valid_i <= fv;
        flow_i <= fe;
        trig_valid_i <= tv;
        trig_i <= te;
        @(posedge clk_i);
        flow_valid_i <= 1'b0;
        trig_valid_i <= 1'b0;
    endtask : push

    task automatic wait_word();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (word_valid_o !== 1'b1 && n < 100);
        check(word_valid_o, 1'b1);
    endtask : wait_word

    // Crossing label of baseline and extended idle words, prompt flags of extended words
    always @(posedge clk_i) begin
        if (rst_i) begin
            wcnt <= 40'h0;
        end else if (word_valid_o === 1'b1) begin
            nwords++;
            if (!ext) begin
                check(word_o[39:0], wcnt);
            end else begin
                check(word_o[47:40], {3'b000, wcnt[15:0] == 16'h0, beam_i.el_fill,
                    beam_i.el_rev, beam_i.had_fill, beam_i.had_rev});
                if (word_o[7:0] === `SL_FLEX_COUNT) begin
                    check(word_o[39:8], wcnt[31:0]);
                end
            end
            wcnt <= ((ext ? word_o[55:48] : word_o[47:40]) === `SL_CMD_RESYNC) ? 40'h0 : wcnt + 40'h1;
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        close_out();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wait_word();
            push(1'b1, {rows[i].code, 24'h0, rows[i].body}, 1'b0, '0);
            wait_word();
            check({word_o[63:40], comma_k_o}, {`SL_COMMA, rows[i].body, rows[i].code, 1'b1});
            repeat (2) @(posedge clk_i);
            check({deadtime_o, link_lent_o}, {rows[i].dt, rows[i].lent});
            $display("row %0d done", i);
        end
        check(trig_seen, 8'h01);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check({word_o, word_valid_o, deadtime_o, link_lent_o, wb_ack_o, flow_ready_o,
            trig_ready_o}, {64'h0, 6'b000011});
        wb(1'b0, `SL_REG_CTRL, 32'h0, rd);
        check(rd, `SL_CTRL_RESET);
        wb(1'b0, 8'h20, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b0, `SL_REG_RC_CMD, 32'h0, rd);
        check(rd, 32'h0);
        $display("reset and registers done");
        wait_word();
        beam_i <= 4'b1010;
        wb(1'b0, `SL_REG_CNT_LO, 32'h0, rd);
        check(rd, wcnt[31:0]);
        wb(1'b0, `SL_REG_CNT_HI, 32'h0, rd);
        check(rd, {24'h0, wcnt[39:32]});
        wb(1'b1, `SL_REG_CTRL, 32'h3, rd);
        ext = 1'b1;
        wb(1'b1, `SL_REG_RC_BODY, pri[2].body, rd);
        wb(1'b1, `SL_REG_RC_CMD, {24'h0, pri[2].code}, rd);
        push(1'b1, pri[0], 1'b1, pri[1]);
        for (k = 0; k < 3; k++) begin
            wait_word();
            check({word_o[55:48], word_o[39:0]}, {pri[k].code, pri[k].body, `SL_FLEX_CMD});
        end
        wait_word();
        check(word_o[55:48], `SL_CMD_IDLE);
        push(1'b1, {`SL_CMD_RESYNC, 32'h0}, 1'b0, '0);
        wait_word();
        wait_word();
        check(word_o[44], 1'b1);
        $display("extended priority done");
        wait_word();
        wb(1'b1, `SL_REG_CTRL, 32'h5, rd);
        ext = 1'b0;
        repeat (2) @(posedge clk_i);
        check(deadtime_o, 1'b1);
        wb(1'b1, `SL_REG_CTRL, 32'h0, rd);
        k = nwords;
        repeat (100) @(posedge clk_i);
        check({deadtime_o, 32'(nwords)}, {1'b0, 32'(k)});
        wb(1'b1, `SL_REG_CTRL, 32'h1, rd);
        $display("dead-time and enable done");
        lend <= 16'h0258;
        wait_word();
        push(1'b1, {`SL_CMD_SEND_CONFIG, 32'h0}, 1'b0, '0);
        wait_word();
        wb(1'b1, `SL_REG_RC_BODY, 32'hc3, rd);
        wb(1'b0, `SL_REG_RC_BODY, 32'h0, rd);
        check(rd, 32'hc3);
        for (k = 0; k < 9; k++) begin
            wb(1'b1, `SL_REG_RC_CMD, 32'(1 + k % 2), rd);
        end
        wb(1'b0, `SL_REG_STATUS, 32'h0, rd);
        check(rd, 32'hd);
        wb(1'b1, `SL_REG_STATUS, 32'h8, rd);
        wb(1'b0, `SL_REG_STATUS, 32'h0, rd);
        check(rd, 32'h5);
        k = 0;
        while (link_lent_o !== 1'b0 && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        check(link_lent_o, 1'b0);
        for (k = 0; k < 9; k++) begin
            wait_word();
            check(word_o[55:40], k < 8 ? {8'hc3, 8'(1 + k % 2)} : 16'h0);
        end
        check(align_err, 8'h00);
        $display("run queue and link lending done");
        close_out();
    end
endmodule : sync_command_link_test
`default_nettype wire
